// ===== common/ubrg_pkg.sv
// Shared constants for the serial port baud rate generator
// Assumes a 32-bit APB bus with word-aligned register offsets
package ubrg_pkg;

  // ****************************************
  // Bus widths and register byte offsets
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFF_TX_CTRL = 8'h00;
  localparam logic [7:0] OFF_RX_CTRL = 8'h04;
  localparam logic [7:0] OFF_BAUD_CTRL = 8'h08;
  localparam logic [7:0] OFF_DIV_HIGH = 8'h0c;
  localparam logic [7:0] OFF_DIV_LOW = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned TX_MASTER_BIT = 7;
  localparam int unsigned TX_SYNC_BIT = 4;
  localparam int unsigned TX_FAST_BIT = 2;
  localparam int unsigned TX_EMPTY_BIT = 1;
  localparam int unsigned BC_IDLE_BIT = 6;
  localparam int unsigned BC_WIDE_BIT = 3;
  localparam int unsigned BC_RSVD_BIT = 2;

  // ****************************************
  // Reset values and read-only masks
  // ****************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] TX_RO_MASK = 8'h02;
  localparam logic [7:0] RX_RO_MASK = 8'h07;
  localparam logic [7:0] BC_RO_MASK = 8'h44;

  // ****************************************
  // Post-divider terminal counts (ratio minus one)
  // ****************************************
  localparam int unsigned POST_W = 6;
  localparam logic [5:0] TERM_64 = 6'h3f;
  localparam logic [5:0] TERM_16 = 6'h0f;
  localparam logic [5:0] TERM_4 = 6'h03;

  // ****************************************
  // Rate modes
  // ****************************************
  typedef enum logic [1:0] {
    UBRG_DIV64 = 2'b00,
    UBRG_DIV16 = 2'b01,
    UBRG_DIV4 = 2'b11
  } ubrg_ratio_t;

endpackage

// ===== rtl/ubrg_timer.sv
// Reloadable down-counter that emits one tick per period
// Assumes one synchronous clock and an active-low synchronous reset
module ubrg_timer #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  input wire logic [WIDTH-1:0] reload_in,
  output logic tick_out,
  output logic [WIDTH-1:0] count_out
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic at_zero;

  // Wrap at zero, or restart on a clear
  assign at_zero = (count_q == '0);
  assign count_d = (clear_in || at_zero) ? reload_in : count_q - 1'b1;
  assign tick_out = at_zero && !clear_in;
  assign count_out = count_q;

  // Count register
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// ===== rtl/ubrg_vote.sv
// Three-sample majority detector for the receive pin
// Assumes the pin is already synchronous to the clock
module ubrg_vote (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic sample_in,
  input wire logic pin_in,
  output logic majority_out,
  output logic latest_out
);

  logic [2:0] hist_q;

  // Shift in one sample per strobe; idle line is high
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      hist_q <= 3'h7;
    end else if (sample_in) begin
      hist_q <= {hist_q[1:0], pin_in};
    end
  end

  // Two of three decide
  assign majority_out = (hist_q[0] & hist_q[1]) | (hist_q[1] & hist_q[2]) |
                        (hist_q[0] & hist_q[2]);
  assign latest_out = hist_q[0];

endmodule

// ===== rtl/ubrg_top.sv
// Baud rate generator with APB register access and receive sampling
// Assumes APB master on clock_in; transmitter and receiver sit outside
//
// The address map and the APB slave port were chosen for this implementation.

// Behaviour
// - Divider 8-bit by default, 16-bit when wide
// - Divisor pair sets free-running timer period
// - Narrow mode ignores the high divisor byte
// - Fast bit ignored in synchronous mode
// - Async narrow slow: clock over 64(n+1)
// - Async one bit set: clock over 16(n+1)
// - Synchronous: clock over 4(n+1)
// - Rate applies except as synchronous slave
// - Divisor write clears the running timer
// - Async not both bits: three-sample majority
// - Single sample in sync or both set
module ubrg_top #(
  parameter int unsigned DIV_W = 16
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ubrg_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [ubrg_pkg::DATA_W-1:0] pwdata_in,
  output logic [ubrg_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic receive_pin_in,
  output logic baud_tick_out,
  output logic prescale_tick_out,
  output logic external_clock_out,
  output logic sample_three_out,
  output logic receive_level_out
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] tx_ctrl_q;
  logic [7:0] rx_ctrl_q;
  logic [7:0] baud_ctrl_q;
  logic [7:0] div_high_q;
  logic [7:0] div_low_q;
  logic [ubrg_pkg::DATA_W-1:0] rdata_q;
  logic err_q;
  logic [ubrg_pkg::POST_W-1:0] post_q;
  logic baud_tick_q;
  logic rx_level_q;

  // ****************************************
  // Bus decode
  // ****************************************
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic hit_tx;
  logic hit_rx;
  logic hit_bc;
  logic hit_dh;
  logic hit_dl;
  logic hit_any;
  logic div_wr;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [7:0] div_high_d;
  logic [7:0] div_low_d;

  // Phase and address decode
  assign setup_ph = psel_in && !penable_in;
  assign access_ph = psel_in && penable_in;
  assign wr_en = access_ph && pwrite_in && hit_any;
  assign hit_tx = (paddr_in == ubrg_pkg::OFF_TX_CTRL);
  assign hit_rx = (paddr_in == ubrg_pkg::OFF_RX_CTRL);
  assign hit_bc = (paddr_in == ubrg_pkg::OFF_BAUD_CTRL);
  assign hit_dh = (paddr_in == ubrg_pkg::OFF_DIV_HIGH);
  assign hit_dl = (paddr_in == ubrg_pkg::OFF_DIV_LOW);
  assign hit_any = hit_tx || hit_rx || hit_bc || hit_dh || hit_dl;
  assign div_wr = wr_en && (hit_dh || hit_dl);
  assign wbyte = pwdata_in[7:0];

  // Divisor bytes as they will stand after this edge
  assign div_high_d = (wr_en && hit_dh) ? wbyte : div_high_q;
  assign div_low_d = (wr_en && hit_dl) ? wbyte : div_low_q;

  // Read mux; status bits show the idle shift register and receiver
  assign rbyte = hit_tx ? (tx_ctrl_q | ubrg_pkg::TX_RO_MASK) :
                 hit_rx ? (rx_ctrl_q & ~ubrg_pkg::RX_RO_MASK) :
                 hit_bc ? ((baud_ctrl_q & ~ubrg_pkg::BC_RO_MASK) |
                           (8'h01 << ubrg_pkg::BC_IDLE_BIT)) :
                 hit_dh ? div_high_q :
                 hit_dl ? div_low_q : ubrg_pkg::RST_BYTE;

  // Zero-wait slave; data and error settle during setup
  assign pready_out = 1'b1;
  assign prdata_out = rdata_q;
  assign pslverr_out = access_ph && err_q;

  // Capture read data and error during the setup cycle
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rdata_q <= '0;
      err_q <= 1'b0;
    end else if (setup_ph) begin
      rdata_q <= {{(ubrg_pkg::DATA_W-8){1'b0}}, rbyte};
      err_q <= !hit_any;
    end
  end

  // Register writes at the access edge
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      tx_ctrl_q <= ubrg_pkg::RST_BYTE;
      rx_ctrl_q <= ubrg_pkg::RST_BYTE;
      baud_ctrl_q <= ubrg_pkg::RST_BYTE;
      div_high_q <= ubrg_pkg::RST_BYTE;
      div_low_q <= ubrg_pkg::RST_BYTE;
    end else if (wr_en) begin
      if (hit_tx) tx_ctrl_q <= wbyte & ~ubrg_pkg::TX_RO_MASK;
      if (hit_rx) rx_ctrl_q <= wbyte & ~ubrg_pkg::RX_RO_MASK;
      if (hit_bc) baud_ctrl_q <= wbyte & ~ubrg_pkg::BC_RO_MASK;
      if (hit_dh) div_high_q <= wbyte;
      if (hit_dl) div_low_q <= wbyte;
    end
  end

  // ****************************************
  // Mode selection
  // ****************************************
  logic sync_mode;
  logic master_mode;
  logic fast_rate_select;
  logic wide_divider_select;
  logic both_set;
  logic own_clock;
  logic [DIV_W-1:0] eff_div;
  ubrg_pkg::ubrg_ratio_t ratio;
  logic [ubrg_pkg::POST_W-1:0] post_term;

  // Control bits
  assign sync_mode = tx_ctrl_q[ubrg_pkg::TX_SYNC_BIT];
  assign master_mode = tx_ctrl_q[ubrg_pkg::TX_MASTER_BIT];
  assign fast_rate_select = tx_ctrl_q[ubrg_pkg::TX_FAST_BIT];
  assign wide_divider_select = baud_ctrl_q[ubrg_pkg::BC_WIDE_BIT];
  assign both_set = wide_divider_select && fast_rate_select;

  // Divisor width; high byte dropped in narrow mode
  // Built from the next byte values so a divisor write reloads the new period at once
  assign eff_div = wide_divider_select ? DIV_W'({div_high_d, div_low_d}) :
                   DIV_W'(div_low_d);

  // Ratio choice; fast bit has no say in synchronous mode
  assign ratio = sync_mode ? ubrg_pkg::UBRG_DIV4 :
                 both_set ? ubrg_pkg::UBRG_DIV4 :
                 (wide_divider_select || fast_rate_select) ? ubrg_pkg::UBRG_DIV16 :
                 ubrg_pkg::UBRG_DIV64;

  // Terminal count of the post-divider
  assign post_term = (ratio == ubrg_pkg::UBRG_DIV4) ? ubrg_pkg::TERM_4 :
                     (ratio == ubrg_pkg::UBRG_DIV16) ? ubrg_pkg::TERM_16 :
                     ubrg_pkg::TERM_64;

  // Own clock everywhere except synchronous slave
  assign own_clock = !sync_mode || master_mode;
  assign external_clock_out = !own_clock;

  // ****************************************
  // Timer and post-divider
  // ****************************************
  logic pre_tick;
  logic post_wrap;
  logic [DIV_W-1:0] timer_count;

  // Free-running timer, restarted by any divisor write
  ubrg_timer #(
    .WIDTH(DIV_W)
  ) u_timer (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .clear_in(div_wr),
    .reload_in(eff_div),
    .tick_out(pre_tick),
    .count_out(timer_count)
  );

  assign prescale_tick_out = pre_tick;
  assign post_wrap = pre_tick && (post_q >= post_term);

  // Post-divider counts timer ticks; cleared with the timer
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      post_q <= '0;
    end else if (div_wr || post_wrap) begin
      post_q <= '0;
    end else if (pre_tick) begin
      post_q <= post_q + 1'b1;
    end
  end

  // Bit-rate strobe, held off when the far party clocks
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      baud_tick_q <= 1'b0;
    end else begin
      baud_tick_q <= post_wrap && own_clock;
    end
  end
  assign baud_tick_out = baud_tick_q;

  // ****************************************
  // Receive pin sampling
  // ****************************************
  logic vote_level;
  logic single_level;

  // Majority unless synchronous or both bits set
  assign sample_three_out = !sync_mode && !both_set;

  ubrg_vote u_vote (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .sample_in(pre_tick),
    .pin_in(receive_pin_in),
    .majority_out(vote_level),
    .latest_out(single_level)
  );

  // Decided receive level
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rx_level_q <= 1'b1;
    end else begin
      rx_level_q <= sample_three_out ? vote_level : single_level;
    end
  end
  assign receive_level_out = rx_level_q;

  // ****************************************
  // Checks
  // ****************************************
  ubrg_pkg::ubrg_ratio_t ratio_q;
  logic steady_q;
  logic ratio_steady;

  // Tracks whether one ratio held since the post-divider last restarted
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ratio_q <= ubrg_pkg::UBRG_DIV64;
      steady_q <= 1'h0;
    end else begin
      ratio_q <= ratio;
      steady_q <= (div_wr || post_wrap) ? 1'h1 : (steady_q && (ratio == ratio_q));
    end
  end

  // A ratio change mid-count wraps early or late by design, so rate checks skip it
  assign ratio_steady = steady_q && (ratio == ratio_q);

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  sequence s_div_write;
    div_wr;
  endsequence

  sequence s_reloaded;
    timer_count == $past(eff_div);
  endsequence

  // Count equals the divisor now held in the registers
  sequence s_new_div;
    timer_count == (wide_divider_select ? DIV_W'({div_high_q, div_low_q}) :
                    DIV_W'(div_low_q));
  endsequence

  a_narrow_high_ignored: assert property (
    !wide_divider_select |-> (eff_div[DIV_W-1:8] == '0))
    else $error("high divisor byte leaks into narrow divider");

  a_write_clears_timer: assert property (
    s_div_write |=> s_new_div)
    else $error("divisor write did not restart the timer");

  a_tick_reloads: assert property (
    (pre_tick && !div_wr) |-> (timer_count == '0) ##1 s_reloaded)
    else $error("timer tick not at zero or no reload");

  a_rate_slow_async: assert property (
    (post_wrap && ratio_steady && !sync_mode && !wide_divider_select && !fast_rate_select)
      |-> (post_q == ubrg_pkg::TERM_64))
    else $error("slow asynchronous ratio is not 64");

  a_rate_mid_async: assert property (
    (post_wrap && ratio_steady && !sync_mode && (wide_divider_select ^ fast_rate_select))
      |-> (post_q == ubrg_pkg::TERM_16))
    else $error("single-bit asynchronous ratio is not 16");

  a_rate_sync_four: assert property (
    (post_wrap && ratio_steady && sync_mode) |-> (post_q == ubrg_pkg::TERM_4))
    else $error("synchronous ratio is not 4");

  a_rate_both_async: assert property (
    (post_wrap && ratio_steady && !sync_mode && both_set) |-> (post_q == ubrg_pkg::TERM_4))
    else $error("both-bit asynchronous ratio is not 4");

  a_slave_no_tick: assert property (
    (sync_mode && !master_mode) [*2] |-> !baud_tick_out)
    else $error("baud strobe while clocked externally");

  a_tick_follows_wrap: assert property (
    post_wrap && own_clock |=> baud_tick_out)
    else $error("baud strobe missing after divider wrap");

  a_single_sample: assert property (
    (sync_mode || both_set) |=> (receive_level_out == $past(single_level)))
    else $error("single-sample level not used");

endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the baud rate generator top module
// Assumes ubrg_pkg and the rtl files are compiled first; the bench is the APB master
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Clock, reset and design hookup
  // ****************************************
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic rx_pin = 1'h1;
  logic [31:0] prdata;
  logic pready, pslverr, baud_tick, pre_tick, ext_clk, three, level;
  int n_mismatch = 0;
  int tests_run = 0;

  // Free-running 200 MHz clock
  always #2.5 clk = ~clk;

  ubrg_top dut (.clock_in(clk), .resetn_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .receive_pin_in(rx_pin),
    .baud_tick_out(baud_tick), .prescale_tick_out(pre_tick), .external_clock_out(ext_clk),
    .sample_three_out(three), .receive_level_out(level));

  // ****************************************
  // Shared tasks
  // ****************************************
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    chk("pready", 32'h1, {31'h0, pready});
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h0, r, e);
    chk(nm, exp, r);
  endtask

  // Count edges until the chosen tick is seen, bounded by lim
  task automatic wait_tick(input logic pre, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while ((pre ? pre_tick : baud_tick) !== 1'h1 && c < lim);
  endtask

  task automatic cfg(input logic [7:0] tx, input logic [7:0] bc);
    wr(ubrg_pkg::OFF_TX_CTRL, {24'h0, tx});
    wr(ubrg_pkg::OFF_BAUD_CTRL, {24'h0, bc});
    wr(ubrg_pkg::OFF_DIV_HIGH, 32'h1);
    wr(ubrg_pkg::OFF_DIV_LOW, 32'h2);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    @(posedge clk);
    chk("sample_three", 32'h1, {31'h0, three});
    chk("external_clock", 32'h0, {31'h0, ext_clk});
    chk("receive_level", 32'h1, {31'h0, level});
    rd("tx_reset", ubrg_pkg::OFF_TX_CTRL, 32'h2);
    rd("baud_ctrl_reset", ubrg_pkg::OFF_BAUD_CTRL, 32'h40);
    rd("div_low_reset", ubrg_pkg::OFF_DIV_LOW, 32'h0);
  endtask

  // Read-only bits, divisor storage and an unmapped address
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    wr(ubrg_pkg::OFF_TX_CTRL, 32'hff);
    rd("tx_rw", ubrg_pkg::OFF_TX_CTRL, 32'hff);
    wr(ubrg_pkg::OFF_RX_CTRL, 32'hff);
    rd("rx_rw", ubrg_pkg::OFF_RX_CTRL, 32'hf8);
    wr(ubrg_pkg::OFF_BAUD_CTRL, 32'hff);
    rd("baud_ctrl_rw", ubrg_pkg::OFF_BAUD_CTRL, 32'hfb);
    wr(ubrg_pkg::OFF_DIV_HIGH, 32'ha5);
    rd("div_high_rw", ubrg_pkg::OFF_DIV_HIGH, 32'ha5);
    apb(1'h0, 8'h14, 32'h0, r, e);
    chk("unmapped_data", 32'h0, r);
    chk("unmapped_err", 32'h1, {31'h0, e});
    apb(1'h0, ubrg_pkg::OFF_DIV_HIGH, 32'h0, r, e);
    chk("mapped_err", 32'h0, {31'h0, e});
    wr(ubrg_pkg::OFF_RX_CTRL, 32'h0);
  endtask

  // Every rate mode: baud period ratio*(n+1), prescale period n+1
  task automatic t_rates();
    logic [7:0] txv [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h90, 8'h94};
    logic [7:0] bcv [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
    int rat [6] = '{64, 16, 16, 4, 4, 4};
    logic thr [6] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
    int n;
    int c;
    for (int i = 0; i < 6; i++) begin
      cfg(txv[i], bcv[i]);
      n = bcv[i][3] ? 259 : 3;
      repeat (3) wait_tick(1'h0, 30000, c);
      chk("baud_period", 32'(rat[i] * n), 32'(c));
      chk("sample_three", {31'h0, thr[i]}, {31'h0, three});
      chk("external_clock", 32'h0, {31'h0, ext_clk});
      repeat (2) wait_tick(1'h1, 1000, c);
      chk("prescale_period", 32'(n), 32'(c));
    end
  endtask

  // Synchronous slave: no internal bit clock
  task automatic t_slave();
    int c;
    cfg(8'h10, 8'h00);
    wait_tick(1'h0, 2000, c);
    chk("slave_no_tick", 32'd2000, 32'(c));
    chk("external_clock", 32'h1, {31'h0, ext_clk});
    chk("sample_three", 32'h0, {31'h0, three});
  endtask

  // Divisor write in mid-count restarts the timer
  task automatic t_restart();
    int c;
    cfg(8'h00, 8'h00);
    wr(ubrg_pkg::OFF_DIV_LOW, 32'hc8);
    repeat (50) @(posedge clk);
    wr(ubrg_pkg::OFF_DIV_LOW, 32'h28);
    wait_tick(1'h1, 1000, c);
    chk("restart_first_tick", 32'd41, 32'(c));
  endtask

  // One-sample pulse on the pin: filtered by the vote, passed in single mode
  task automatic t_glitch(input string nm, input logic exp_seen);
    int c;
    logic seen;
    seen = 1'h0;
    rx_pin <= 1'h0;
    repeat (20) @(posedge clk);
    chk("level_low", 32'h0, {31'h0, level});
    wait_tick(1'h1, 100, c);
    rx_pin <= 1'h1;
    repeat (3) @(posedge clk);
    rx_pin <= 1'h0;
    repeat (12) begin
      @(posedge clk);
      if (level === 1'h1) seen = 1'h1;
    end
    chk(nm, {31'h0, exp_seen}, {31'h0, seen});
    rx_pin <= 1'h1;
  endtask

  task automatic t_vote();
    cfg(8'h00, 8'h00);
    t_glitch("majority_glitch", 1'h0);
    cfg(8'h04, 8'h08);
    wr(ubrg_pkg::OFF_DIV_HIGH, 32'h0);
    t_glitch("single_glitch", 1'h1);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_regs();
    t_rates();
    t_slave();
    t_restart();
    t_vote();
    print_verdict();
  end

  // Cuts a hang short well above the expected run length
  initial begin
    #(5.0 * 100000);
    n_mismatch++;
    print_verdict();
  end
endmodule
